// >>> csi_status_indicator.sv
// module: led sequencing, alarm reporting and apb registers
`timescale 1ns/1ps
`default_nettype none
module csi_status_indicator
    import csi_pkg::*;
#(
    parameter int FAST_HALF_P = FAST_HALF,
    parameter int MID_HALF_P = MID_HALF,
    parameter int SLOW_HALF_P = SLOW_HALF,
    parameter int RUNUP_P = RUNUP_CYC,
    parameter int LAMP_P = LAMP_CYC
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic led_green,
    output logic led_yellow,
    output logic [7:0] error_class_out,
    output logic [7:0] error_code_out,
    output logic comm_error,
    output logic bus_restricted,
    output logic [15:0] channel_event_word,
    output logic [15:0] channel_transfer_status,
    output logic irq
);
    localparam int NB = 3;
    localparam int HALF [NB] = '{FAST_HALF_P, MID_HALF_P, SLOW_HALF_P};

    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [IRQ_W-1:0] istat_q, istat_d, imask_q, imask_d;
    logic [31:0] prdata_q, prdata_d;
    logic [7:0] ecl_q, ecl_d, eco_q, eco_d;
    logic [15:0] evw_q, evw_d, trs_q, trs_d;
    csi_phase_type ph_q, ph_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic g_q, g_d, y_q, y_d;
    wire [NB-1:0] blink;
    csi_led_type gm, ym;
    logic wr, rd, hit, ev_err, ev_runup, ev_load, ev_alarm;
    logic [7:0] alarm;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign hit = (paddr == CTRL_OFF) || (paddr == STAT_OFF)
        || (paddr == ISTAT_OFF) || (paddr == IMASK_OFF)
        || (paddr == ERRCLR_OFF);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // blink timebases, toggling at each half period
    genvar gi;
    generate
        for (gi = 0; gi < NB; gi++)
        begin : g_blink
            logic [TMR_W-1:0] cnt_q, cnt_d;
            logic lvl_q, lvl_d;
            always_comb
            begin
                cnt_d = cnt_q + 1'b1;
                lvl_d = lvl_q;
                if (cnt_q == TMR_W'(HALF[gi] - 1))
                begin
                    cnt_d = '0;
                    lvl_d = !lvl_q;
                end
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    cnt_q <= '0;
                    lvl_q <= 1'b0;
                end
                else
                begin
                    cnt_q <= cnt_d;
                    lvl_q <= lvl_d;
                end
            end
            assign blink[gi] = lvl_q;
        end
    endgenerate

    // lowest-numbered alarm wins
    always_comb
    begin
        if (ctrl_q[CB_DBP] && !ctrl_q[CB_DBA])
            alarm = EC_NOACT;
        else if (!ctrl_q[CB_DBP])
            alarm = EC_NODB;
        else if (ctrl_q[CB_LOAD])
            alarm = EC_LOAD;
        else if (ctrl_q[CB_RES])
            alarm = EC_RES;
        else if (ctrl_q[CB_BUSF])
            alarm = EC_BUSF;
        else
            alarm = EC_OK;
    end

    // indicator modes in severity order
    always_comb
    begin
        if (!ctrl_q[CB_RUN])
            gm = LM_OFF;
        else if (ctrl_q[CB_FATAL])
            gm = LM_FAST;
        else if (!ctrl_q[CB_SYNC])
            gm = LM_MID;
        else
            gm = LM_ON;
        // raw bus activity is deliberately not an input here
        if (ctrl_q[CB_BUSF])
            ym = LM_FAST;
        else if (!ctrl_q[CB_DBP] || !ctrl_q[CB_DBA])
            ym = LM_MID;
        else if (!ctrl_q[CB_BUSOP])
            ym = LM_OFF;
        else if (ctrl_q[CB_PART])
            ym = LM_SLOW;
        else
            ym = LM_ON;
    end

    function automatic logic led_of(csi_led_type m, logic [NB-1:0] b);
        case (m)
            LM_ON: led_of = 1'b1;
            LM_FAST: led_of = b[0];
            LM_MID: led_of = b[1];
            LM_SLOW: led_of = b[2];
            default: led_of = 1'b0;
        endcase
    endfunction

    // run-up sequencer
    always_comb
    begin
        ph_d = ph_q;
        tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
        g_d = g_q;
        y_d = y_q;
        ev_runup = 1'b0;
        ev_load = 1'b0;
        case (ph_q)
            PH_LAMP:
            begin
                g_d = 1'b1;
                y_d = 1'b1;
                if (tmr_q == '0)
                begin
                    ph_d = PH_DARK;
                    tmr_d = TMR_W'(LAMP_P - 1);
                end
            end
            PH_DARK:
            begin
                g_d = 1'b0;
                y_d = 1'b0;
                if (tmr_q == '0)
                begin
                    ph_d = PH_RUNUP;
                    tmr_d = TMR_W'(RUNUP_P - 1);
                end
            end
            PH_RUNUP:
            begin
                g_d = 1'b1;
                y_d = 1'b0;
                if (tmr_q == '0)
                begin
                    ph_d = PH_RUN;
                    ev_runup = 1'b1;
                end
            end
            PH_RUN:
            begin
                g_d = led_of(gm, blink);
                y_d = led_of(ym, blink);
                if (ctrl_q[CB_LOAD])
                    ph_d = PH_LOAD;
            end
            PH_LOAD:
            begin
                g_d = led_of(gm, blink);
                y_d = blink[1];
                if (!ctrl_q[CB_LOAD])
                begin
                    ph_d = PH_LAMP;
                    tmr_d = TMR_W'(LAMP_P - 1);
                    ev_load = 1'b1;
                end
            end
            PH_HOLD:
            begin
                // leds frozen: software has not yet taken them back
                if (ctrl_q[CB_RUN])
                begin
                    ph_d = PH_RUNUP;
                    tmr_d = TMR_W'(RUNUP_P - 1);
                end
            end
            default: ph_d = PH_LAMP;
        endcase
        if (wr && paddr == CTRL_OFF && pwdata[CB_SRST])
        begin
            ph_d = PH_HOLD;
            g_d = g_q;
            y_d = y_q;
        end
    end

    // registers, alarm and error reporting
    always_comb
    begin
        ctrl_d = ctrl_q;
        imask_d = imask_q;
        ecl_d = ecl_q;
        eco_d = alarm;
        prdata_d = prdata_q;
        ev_err = 1'b0;
        ev_alarm = (alarm != eco_q);
        if (wr && paddr == CTRL_OFF)
        begin
            ctrl_d = pwdata[CTRL_W-1:0];
            ctrl_d[CB_SRST] = 1'b0;
            if (pwdata[CB_SRST])
                ctrl_d[CB_RUN] = 1'b0;
        end
        if (wr && paddr == IMASK_OFF)
            imask_d = pwdata[IRQ_W-1:0];
        // host reset clears the class only once the cause is gone
        if (wr && paddr == ERRCLR_OFF && pwdata[0]
            && !ctrl_q[CB_FATAL])
            ecl_d = ECL_ALARM;
        if (ctrl_q[CB_FATAL]) // set wins over the clear
        begin
            ecl_d = ECL_FATAL;
            ev_err = (ecl_q == ECL_ALARM);
        end
        // slave failures never reach the indicators
        evw_d = ctrl_q[CB_SFAIL] ? EVW_BREAK : 16'h0000;
        trs_d = ctrl_q[CB_SFAIL] ? TRS_BREAK : 16'h0000;
        istat_d = istat_q;
        if (wr && paddr == ISTAT_OFF)
            istat_d = istat_q & ~pwdata[IRQ_W-1:0];
        istat_d[IB_ERR] = istat_d[IB_ERR] | ev_err;
        istat_d[IB_RUNUP] = istat_d[IB_RUNUP] | ev_runup;
        istat_d[IB_LOAD] = istat_d[IB_LOAD] | ev_load;
        istat_d[IB_ALARM] = istat_d[IB_ALARM] | ev_alarm;
        if (rd)
        begin
            if (paddr == CTRL_OFF)
                prdata_d = {20'h00000, ctrl_q};
            else if (paddr == STAT_OFF)
                prdata_d = {11'h000, ph_q, g_q, y_q, ecl_q, eco_q};
            else if (paddr == ISTAT_OFF)
                prdata_d = {28'h0000000, istat_q};
            else if (paddr == IMASK_OFF)
                prdata_d = {28'h0000000, imask_q};
            else
                prdata_d = 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST;
            imask_q <= '0;
            istat_q <= '0;
            ecl_q <= ECL_ALARM;
            eco_q <= EC_OK;
            evw_q <= 16'h0000;
            trs_q <= 16'h0000;
            prdata_q <= 32'h00000000;
            ph_q <= PH_LAMP;
            tmr_q <= TMR_W'(LAMP_P - 1);
            g_q <= 1'b0;
            y_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            imask_q <= imask_d;
            istat_q <= istat_d;
            ecl_q <= ecl_d;
            eco_q <= eco_d;
            evw_q <= evw_d;
            trs_q <= trs_d;
            prdata_q <= prdata_d;
            ph_q <= ph_d;
            tmr_q <= tmr_d;
            g_q <= g_d;
            y_q <= y_d;
        end
    end

    assign prdata = prdata_q;
    assign led_green = g_q;
    assign led_yellow = y_q;
    assign error_class_out = ecl_q;
    assign error_code_out = eco_q;
    assign comm_error = (ecl_q != ECL_ALARM);
    assign bus_restricted = ctrl_q[CB_PART];
    assign channel_event_word = evw_q;
    assign channel_transfer_status = trs_q;
    assign irq = |(istat_q & imask_q);

    // checks
    AST_GREEN_DARK: assert property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_RUN && !ctrl_q[CB_RUN] && ph_d == PH_RUN |=> !led_green)
        else $error("green lit while processor stopped");
    AST_GREEN_FAST: assert property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_RUN && ph_d == PH_RUN && ctrl_q[CB_RUN]
        && ctrl_q[CB_FATAL] |=> led_green == $past(blink[0]))
        else $error("green not on fast flash under fatal error");
    AST_GREEN_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_RUN && ph_d == PH_RUN && ctrl_q[CB_RUN]
        && !ctrl_q[CB_FATAL] && !ctrl_q[CB_SYNC]
        |=> led_green == $past(blink[1]))
        else $error("green not on 1 s flash while waiting");
    AST_YEL_BUSF: assert property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_RUN && ph_d == PH_RUN && ctrl_q[CB_BUSF]
        |=> led_yellow == $past(blink[0]))
        else $error("yellow not on fast flash under bus fault");
    AST_YEL_SLOW: assert property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_RUN && ph_d == PH_RUN && ym == LM_SLOW
        |-> bus_restricted ##1 led_yellow == $past(blink[2]))
        else $error("partial match not shown as slow flash");
    AST_RUNUP: assert property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_RUNUP && ph_d == PH_RUNUP |=> led_green && !led_yellow)
        else $error("run-up must show green only");
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_HOLD |=> $stable(led_green) && $stable(led_yellow))
        else $error("leds changed while held after module reset");
    AST_LOAD_END: assert property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_LOAD && !ctrl_q[CB_LOAD] && ph_d != PH_HOLD
        |=> ph_q == PH_LAMP ##1 led_green && led_yellow)
        else $error("download end did not restart run-up");
    AST_ALARM: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[CB_DBP] && !ctrl_q[CB_DBA] |=> error_code_out == EC_NOACT)
        else $error("lowest alarm code not reported");
    AST_ERR_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        comm_error && !(wr && paddr == ERRCLR_OFF && pwdata[0])
        |=> comm_error)
        else $error("comm error cleared without host reset");
    AST_SLAVE: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[CB_SFAIL] |=> channel_transfer_status == TRS_BREAK
        && channel_event_word == EVW_BREAK)
        else $error("slave failure not on channel status");
    COV_RUNUP: cover property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_RUNUP ##1 ph_q == PH_RUN);
    COV_LOAD: cover property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_LOAD ##1 ph_q == PH_LAMP);
    COV_ERR: cover property (@(posedge pclk) disable iff (!presetn)
        comm_error ##1 !comm_error);
    COV_HOLD: cover property (@(posedge pclk) disable iff (!presetn)
        ph_q == PH_HOLD ##1 ph_q == PH_RUNUP);
endmodule // csi_status_indicator
`default_nettype wire

// >>> csi_pkg.sv
// package: constants and types for the comm module status indicator
package csi_pkg;
    localparam int CLK_KHZ = 50000;
    localparam int FAST_MS = 200;
    localparam int MID_MS = 1000;
    localparam int SLOW_MS = 2000;
    localparam int RUNUP_MS = 5000;
    localparam int LAMP_MS = 500;
    // half periods, since each flash has equal on and off time
    localparam int FAST_HALF = FAST_MS * CLK_KHZ / 2;
    localparam int MID_HALF = MID_MS * CLK_KHZ / 2;
    localparam int SLOW_HALF = SLOW_MS * CLK_KHZ / 2;
    localparam int RUNUP_CYC = RUNUP_MS * CLK_KHZ;
    localparam int LAMP_CYC = LAMP_MS * CLK_KHZ;
    localparam int TMR_W = 28;
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STAT_OFF = 12'h004;
    localparam logic [11:0] ISTAT_OFF = 12'h008;
    localparam logic [11:0] IMASK_OFF = 12'h00c;
    localparam logic [11:0] ERRCLR_OFF = 12'h010;
    localparam int CB_RUN = 0;
    localparam int CB_SYNC = 1;
    localparam int CB_FATAL = 2;
    localparam int CB_BUSF = 3;
    localparam int CB_DBP = 4;
    localparam int CB_DBA = 5;
    localparam int CB_PART = 6;
    localparam int CB_LOAD = 7;
    localparam int CB_BUSOP = 8;
    localparam int CB_SRST = 9;
    localparam int CB_RES = 10;
    localparam int CB_SFAIL = 11;
    localparam int CTRL_W = 12;
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam int IB_ERR = 0;
    localparam int IB_RUNUP = 1;
    localparam int IB_LOAD = 2;
    localparam int IB_ALARM = 3;
    localparam int IRQ_W = 4;
    localparam logic [7:0] EC_OK = 8'h00;
    localparam logic [7:0] EC_NOACT = 8'h01;
    localparam logic [7:0] EC_NODB = 8'h02;
    localparam logic [7:0] EC_LOAD = 8'h03;
    localparam logic [7:0] EC_RES = 8'h08;
    localparam logic [7:0] EC_BUSF = 8'h0a;
    localparam logic [7:0] ECL_ALARM = 8'h00;
    localparam logic [7:0] ECL_FATAL = 8'h01;
    localparam logic [15:0] EVW_BREAK = 16'h0002;
    localparam logic [15:0] TRS_BREAK = 16'h6014;
    typedef enum logic [2:0] {
        PH_LAMP = 3'b000, PH_DARK = 3'b001, PH_RUNUP = 3'b010,
        PH_RUN = 3'b011, PH_LOAD = 3'b100, PH_HOLD = 3'b101
    } csi_phase_type;
    typedef enum logic [2:0] {
        LM_OFF = 3'b000, LM_ON = 3'b001, LM_FAST = 3'b010,
        LM_MID = 3'b011, LM_SLOW = 3'b100
    } csi_led_type;
endpackage

// >>> csi_host_model.sv
// apb host model standing in for the controller cpu
`timescale 1ns/1ps
`default_nettype none
module csi_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // idle edge first, so psel never takes two values in one step
    task automatic xfer(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the bench timeout may end this wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data must not look like the last value
        pwdata <= ~d;
    endtask
endmodule // csi_host_model
`default_nettype wire

// >>> tb_comm_module_status_indicator.sv
// testbench for the comm module status indicator
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module tb_comm_module_status_indicator import csi_pkg::*;;
    localparam int FH = 4, MH = 8, SH = 16, RU = 64, LP = 8;
    typedef struct {
        logic [11:0] ctrl;
        int g;
        int y;
        logic [7:0] code;
    } csi_row_type;
    // ctrl word, green, yellow (0 off, 1 on, else half period), code
    csi_row_type rows [12] = '{
        '{12'h133, 1, 1, EC_OK}, '{12'h132, 0, 1, 8'hff},
        '{12'h131, MH, 1, 8'hff}, '{12'h13b, 1, FH, EC_BUSF},
        '{12'h123, 1, MH, EC_NODB}, '{12'h113, 1, MH, EC_NOACT},
        '{12'h033, 1, 0, 8'hff}, '{12'h173, 1, SH, 8'hff},
        '{12'h17b, 1, FH, 8'hff}, '{12'h533, 1, 1, EC_RES},
        '{12'h53b, 1, FH, EC_RES}, '{12'h137, FH, 1, 8'hff}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic led_green, led_yellow, comm_error, bus_restricted;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] error_class_out, error_code_out;
    logic [15:0] channel_event_word, channel_transfer_status;
    int err_total = 0, checks = 0, cyc = 0;
    csi_status_indicator #(.FAST_HALF_P(FH), .MID_HALF_P(MH),
        .SLOW_HALF_P(SH), .RUNUP_P(RU), .LAMP_P(LP)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .led_green(led_green), .led_yellow(led_yellow),
        .error_class_out(error_class_out),
        .error_code_out(error_code_out), .comm_error(comm_error),
        .bus_restricted(bus_restricted),
        .channel_event_word(channel_event_word),
        .channel_transfer_status(channel_transfer_status), .irq(irq));
    csi_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic print_verdict();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            err_total++;
            print_verdict();
        end
    end
    // registered outputs need a settled look after the write edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        host.xfer(1'b1, a, d, q, e);
        @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] q,
        output logic e);
        host.xfer(1'b0, a, 32'h0, q, e);
        @(negedge pclk);
    endtask
    // gap between two toggles, or the steady level when none
    task automatic meas(input bit yel, output int res);
        logic prev, cur;
        int t0;
        t0 = -1;
        res = -1;
        prev = yel ? led_yellow : led_green;
        cur = prev;
        for (int n = 0; n < 40 && res < 0; n++)
        begin
            @(posedge pclk);
            cur = yel ? led_yellow : led_green;
            if (cur !== prev)
            begin
                if (t0 >= 0)
                    res = n - t0;
                t0 = n;
            end
            prev = cur;
        end
        if (res < 0)
            res = (cur === 1'b1) ? 1 : ((cur === 1'b0) ? 0 : 2);
    endtask
    initial
    begin
        logic [31:0] q;
        logic e;
        int r;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        `CHK({led_green, led_yellow, irq, comm_error}, 4'h0)
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK({led_green, led_yellow}, 2'h3)
        rd(STAT_OFF, q, e);
        `CHK(q[20:18], 3'h0)
        // soft reset lands before the dark phase reaches the leds
        wr(CTRL_OFF, 32'h200);
        rd(12'h100, q, e);
        `CHK({e, q, pready}, 34'h200000001)
        wr(IMASK_OFF, 32'h2);
        repeat (5) @(posedge pclk);
        `CHK({led_green, led_yellow}, 2'h3)
        rd(STAT_OFF, q, e);
        `CHK(q[20:18], 3'h5)
        wr(CTRL_OFF, 32'h133);
        repeat (4) @(posedge pclk);
        `CHK({led_green, led_yellow}, 2'h2)
        repeat (RU + 4) @(posedge pclk);
        `CHK({led_green, led_yellow, irq}, 3'h7)
        wr(ISTAT_OFF, 32'hf);
        wr(IMASK_OFF, 32'h0);
        `CHK(irq, 1'b0)
        for (int i = 0; i < 12; i++)
        begin
            wr(CTRL_OFF, {20'h0, rows[i].ctrl});
            repeat (3) @(posedge pclk);
            if (rows[i].code !== 8'hff)
            begin
                `CHK(error_code_out, rows[i].code)
            end
            `CHK(bus_restricted, rows[i].ctrl[6])
            meas(1'b0, r);
            `CHK(r, rows[i].g)
            meas(1'b1, r);
            `CHK(r, rows[i].y)
        end
        `CHK({comm_error, error_class_out}, 9'h101)
        rd(ISTAT_OFF, q, e);
        `CHK({irq, q[0]}, 2'h1)
        wr(IMASK_OFF, 32'h1);
        `CHK(irq, 1'b1)
        wr(ISTAT_OFF, 32'h1);
        `CHK(irq, 1'b0)
        // clearing is refused while the fatal cause is still present
        wr(ERRCLR_OFF, 32'h1);
        wr(CTRL_OFF, 32'h133);
        `CHK(error_class_out, 8'h01)
        wr(ERRCLR_OFF, 32'h1);
        `CHK({comm_error, error_class_out}, 9'h000)
        wr(CTRL_OFF, 32'h933);
        `CHK({channel_event_word, channel_transfer_status}, 32'h00026014)
        meas(1'b1, r);
        `CHK(r, 1)
        wr(CTRL_OFF, 32'h1b3);
        repeat (3) @(posedge pclk);
        `CHK(error_code_out, 8'h03)
        meas(1'b1, r);
        `CHK(r, MH)
        wr(CTRL_OFF, 32'h133);
        repeat (3) @(posedge pclk);
        `CHK({led_green, led_yellow}, 2'h3)
        repeat (LP) @(posedge pclk);
        `CHK({led_green, led_yellow}, 2'h0)
        repeat (LP) @(posedge pclk);
        `CHK({led_green, led_yellow}, 2'h2)
        repeat (RU + 6) @(posedge pclk);
        `CHK({led_green, led_yellow}, 2'h3)
        print_verdict();
    end
endmodule // tb_comm_module_status_indicator
`default_nettype wire
